// ### sts_seq.sv
// self-tuning sequencer: step qualification, phases, status word, registers
//
// Notes on behaviour
// - each run opens with a zero-output monitoring phase of about one minute
// - step controller monitoring adds half the actuator travel time
// - after monitoring the output goes to full scale, seen on manipulated_output
// - record elapsed time at 1 and 4 percent rise; only first 4 percent used
// - run finished when output leaves full scale; control goes on with new values
// - while request stays set, each later qualifying step starts a fresh run
// - start needs step above 5 degrees and setpoint above actual plus 0.12 limit
// - lowering then raising setpoint also starts, if the margin condition holds
// - critical system cancels run into error state, output zero until new run
// - negative step below start threshold aborts a running identification
// - clearing the request bit does not stop a run in progress
// - setpoint never reached with output stuck means the run failed
// - status word is 16 bits of four nibbles; top nibble always zero
// - action nibble: 0 manual, 2 closed loop, 4 optimizing, 6 transition
// - identification nibble: bit 0 running, bit 1 unsaved new parameters
// - error nibble: 0 none, 4 value jump, 5 delay ratio, 6 unsettled start
`timescale 1ns/1ns
`default_nettype none
`include "sts_cfg.svh"
module sts_seq
    import sts_pkg::*;
#(
    parameter int TICK_CYC = `STS_TICK_CYC,
    parameter int MON_MS   = `STS_MON_MS,
    parameter int FAIL_MS  = `STS_FAIL_MS,
    parameter int TRANS_MS = `STS_TRANS_MS
)(
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_N_IN,
    // register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic [31:0]      RDATA_OUT,
    // process values
    input  wire logic [15:0] SETPOINT_IN,
    input  wire logic [15:0] ACTUAL_IN,
    input  wire logic        AUTO_MODE_IN,
    input  wire logic [15:0] CTRL_OUT_IN,
    // findings of the parameter computation
    input  wire logic        JUMP_ERR_IN,
    input  wire logic        RATIO_ERR_IN,
    input  wire logic        UNSETTLED_IN,
    // results
    output logic [15:0]      MANIP_OUT,
    output logic             RUNNING_OUT,
    output logic [15:0]      STATUS_WORD_OUT,
    output logic             IRQ_OUT
);

    function automatic logic [15:0] pct(input logic [15:0] val, input logic [6:0] p);
        logic [31:0] prod;
        prod = {16'h0, val} * {25'h0, p};
        pct  = 16'(prod / 32'd100);
    endfunction

    // registers
    sts_state_t  state_r;
    sts_state_t  state_nxt;
    logic [1:0]  ctrl_r;
    logic [15:0] travel_r;
    logic [15:0] limit_r;
    logic [31:0] t1_r;
    logic [31:0] t4_r;
    logic        t1_seen_r;
    logic [15:0] sp_prev_r;
    logic [15:0] act_base_r;
    logic [3:0]  err_r;
    logic [3:0]  err_nxt;
    logic        newpar_r;
    logic        auto_prev_r;
    logic [31:0] trans_r;
    logic [15:0] manip_r;
    logic [`STS_IRQ_W-1:0] irq_stat_r;
    logic [`STS_IRQ_W-1:0] irq_mask_r;
    logic [31:0] rdata_r;

    // timer
    logic        tick;
    logic [31:0] elapsed_ms;
    logic        tmr_clr;

    sts_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_timer (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .clear_in (tmr_clr),
        .tick_out (tick),
        .ms_out   (elapsed_ms)
    );

    // register decode
    wire wr_ctrl   = WR_IN && (ADDR_IN == `STS_OFS_CTRL);
    wire wr_travel = WR_IN && (ADDR_IN == `STS_OFS_TRAVEL);
    wire wr_limit  = WR_IN && (ADDR_IN == `STS_OFS_LIMIT);
    wire wr_istat  = WR_IN && (ADDR_IN == `STS_OFS_IRQ_STAT);
    wire wr_imask  = WR_IN && (ADDR_IN == `STS_OFS_IRQ_MASK);
    wire req       = ctrl_r[`STS_CTRL_REQ];
    wire step_ctl  = ctrl_r[`STS_CTRL_STEPCTL];
    wire saved     = wr_ctrl && WDATA_IN[`STS_CTRL_SAVED];

    // setpoint step qualification
    wire [15:0] margin    = pct(limit_r, `STS_PCT_START);
    wire [16:0] threshold = {1'b0, ACTUAL_IN} + {1'b0, margin};
    wire        sp_up     = SETPOINT_IN > sp_prev_r;
    wire        sp_dn     = SETPOINT_IN < sp_prev_r;
    wire [15:0] step_sz   = SETPOINT_IN - sp_prev_r;
    wire        above     = {1'b0, SETPOINT_IN} > threshold;
    // compared against the previous sample, so a raise after a lowering counts
    wire        big_step  = (step_sz > `STS_MIN_STEP) && (step_sz >= margin);
    wire        qualify   = req && sp_up && big_step && above;
    wire        running   = (state_r == STS_MONITOR) || (state_r == STS_HEAT);
    wire        abort     = running && sp_dn && !above;

    // phase timing
    wire [31:0] half_travel = {16'h0, travel_r} * `STS_HALF_S_MS;
    wire [31:0] mon_len     = 32'(MON_MS) + (step_ctl ? half_travel : 32'h0);
    wire        mon_over    = elapsed_ms >= mon_len;
    wire        heat_fail   = elapsed_ms >= 32'(FAIL_MS);

    // temperature rise since full power began
    wire [15:0] rise   = (ACTUAL_IN > act_base_r) ? ACTUAL_IN - act_base_r : 16'h0;
    wire        rise1  = rise >= pct(limit_r, `STS_PCT_RISE1);
    wire        rise4  = rise >= pct(limit_r, `STS_PCT_RISE4);

    // critical system findings, first listed wins
    wire        crit   = running && (JUMP_ERR_IN || RATIO_ERR_IN || UNSETTLED_IN);

    // state sequencing; abort has priority, a new step restarts the run
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            STS_IDLE, STS_ERROR: begin
                if (qualify) begin
                    state_nxt = STS_MONITOR;
                end
            end
            STS_MONITOR: begin
                if (abort) begin
                    state_nxt = STS_IDLE;
                end else if (crit) begin
                    state_nxt = STS_ERROR;
                end else if (qualify) begin
                    state_nxt = STS_MONITOR;
                end else if (mon_over) begin
                    state_nxt = STS_HEAT;
                end
            end
            STS_HEAT: begin
                if (abort) begin
                    state_nxt = STS_IDLE;
                end else if (crit) begin
                    state_nxt = STS_ERROR;
                end else if (qualify) begin
                    state_nxt = STS_MONITOR;
                end else if (rise4) begin
                    state_nxt = STS_IDLE;
                end else if (heat_fail) begin
                    state_nxt = STS_ERROR;
                end
            end
        endcase
    end

    // request bit only gates restarts once running; clearing it does not stop a run
    wire ev_start = qualify;
    wire ev_heat  = (state_r == STS_MONITOR) && (state_nxt == STS_HEAT);
    wire ev_done  = (state_r == STS_HEAT) && !abort && !crit && !qualify && rise4;
    wire ev_abort = abort;
    wire ev_err   = crit && !abort;
    wire ev_fail  = (state_r == STS_HEAT) && (state_nxt == STS_ERROR) && !crit;
    wire [`STS_IRQ_W-1:0] irq_ev = {ev_fail, ev_err, ev_abort, ev_done, ev_heat, ev_start};

    assign tmr_clr = (state_nxt != state_r) || qualify;

    // error code: cleared by a new run, set by a finding
    always_comb begin
        err_nxt = err_r;
        if (ev_err) begin
            if (JUMP_ERR_IN) begin
                err_nxt = `STS_ERR_JUMP;
            end else if (RATIO_ERR_IN) begin
                err_nxt = `STS_ERR_RATIO;
            end else begin
                err_nxt = `STS_ERR_UNSETTLED;
            end
        end else if (ev_start) begin
            err_nxt = `STS_ERR_NONE;
        end
    end

    // manipulated value per phase
    wire [15:0] manip_nxt =
        (state_nxt == STS_HEAT)    ? `STS_OUT_FULL :
        (state_nxt == STS_MONITOR) ? `STS_OUT_ZERO :
        (state_nxt == STS_ERROR)   ? `STS_OUT_ZERO :
        CTRL_OUT_IN;

    // status word nibbles
    wire [3:0] action =
        !AUTO_MODE_IN     ? `STS_ACT_MANUAL :
        (trans_r != 32'h0) ? `STS_ACT_TRANS :
        req               ? `STS_ACT_OPTIM :
        `STS_ACT_CLOSED;
    sts_word_t word;
    assign word = '{unused: 4'h0,
                    action: action,
                    ident:  {2'b00, newpar_r, running},
                    err:    err_r};
    wire [15:0] word_bits = word;

    // read mux
    wire [31:0] rd_mux =
        (ADDR_IN == `STS_OFS_CTRL)     ? {30'h0, ctrl_r} :
        (ADDR_IN == `STS_OFS_TRAVEL)   ? {16'h0, travel_r} :
        (ADDR_IN == `STS_OFS_LIMIT)    ? {16'h0, limit_r} :
        (ADDR_IN == `STS_OFS_STATUS)   ? {16'h0, word_bits} :
        (ADDR_IN == `STS_OFS_T1)       ? t1_r :
        (ADDR_IN == `STS_OFS_T4)       ? t4_r :
        (ADDR_IN == `STS_OFS_IRQ_STAT) ? {26'h0, irq_stat_r} :
        (ADDR_IN == `STS_OFS_IRQ_MASK) ? {26'h0, irq_mask_r} :
        32'h0;

    // sequencer state
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            state_r <= STS_IDLE;
            err_r   <= `STS_ERR_NONE;
            manip_r <= `STS_OUT_ZERO;
        end else begin
            state_r <= state_nxt;
            err_r   <= err_nxt;
            manip_r <= manip_nxt;
        end
    end

    // setpoint history and rise base
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            sp_prev_r  <= 16'h0;
            act_base_r <= 16'h0;
        end else begin
            sp_prev_r <= SETPOINT_IN;
            if (ev_heat) begin
                act_base_r <= ACTUAL_IN;
            end
        end
    end

    // rise timestamps, only the first 4 percent is measured
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            t1_r      <= 32'h0;
            t4_r      <= 32'h0;
            t1_seen_r <= 1'b0;
        end else if (ev_heat) begin
            t1_r      <= 32'h0;
            t4_r      <= 32'h0;
            t1_seen_r <= 1'b0;
        end else if (state_r == STS_HEAT) begin
            if (rise1 && !t1_seen_r) begin
                t1_r      <= elapsed_ms;
                t1_seen_r <= 1'b1;
            end
            if (ev_done) begin
                t4_r <= elapsed_ms;
            end
        end
    end

    // new parameters pending storage; completion beats a save request
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            newpar_r <= 1'b0;
        end else begin
            newpar_r <= ev_done || (newpar_r && !saved);
        end
    end

    // manual-to-automatic transition display
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            auto_prev_r <= 1'b0;
            trans_r     <= 32'h0;
        end else begin
            auto_prev_r <= AUTO_MODE_IN;
            if (!AUTO_MODE_IN) begin
                trans_r <= 32'h0;
            end else if (!auto_prev_r) begin
                trans_r <= 32'(TRANS_MS);
            end else if (tick && trans_r != 32'h0) begin
                trans_r <= trans_r - 32'h1;
            end
        end
    end

    // software registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_r     <= `STS_CTRL_RST;
            travel_r   <= `STS_TRAVEL_RST;
            limit_r    <= `STS_LIMIT_RST;
            irq_mask_r <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= WDATA_IN[1:0];
            end
            if (wr_travel) begin
                travel_r <= WDATA_IN[15:0];
            end
            if (wr_limit) begin
                limit_r <= WDATA_IN[15:0];
            end
            if (wr_imask) begin
                irq_mask_r <= WDATA_IN[`STS_IRQ_W-1:0];
            end
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? WDATA_IN[`STS_IRQ_W-1:0] : '0)) | irq_ev;
        end
    end

    // read data stand for the one cycle after the strobe
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= RD_IN ? rd_mux : 32'h0;
        end
    end

    assign RDATA_OUT       = rdata_r;
    assign MANIP_OUT       = manip_r;
    assign RUNNING_OUT     = running;
    assign STATUS_WORD_OUT = word_bits;
    assign IRQ_OUT         = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// ### sts_cfg.svh
// constants for the temperature self-tuning sequencer
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// register offsets, byte addresses
`define STS_OFS_CTRL      8'h00
`define STS_OFS_TRAVEL    8'h04
`define STS_OFS_LIMIT     8'h08
`define STS_OFS_STATUS    8'h0c
`define STS_OFS_T1        8'h10
`define STS_OFS_T4        8'h14
`define STS_OFS_IRQ_STAT  8'h18
`define STS_OFS_IRQ_MASK  8'h1c

// control register fields
`define STS_CTRL_REQ      0
`define STS_CTRL_STEPCTL  1
`define STS_CTRL_SAVED    2

// interrupt status bits
`define STS_IRQ_START     0
`define STS_IRQ_HEAT      1
`define STS_IRQ_DONE      2
`define STS_IRQ_ABORT     3
`define STS_IRQ_ERROR     4
`define STS_IRQ_FAIL      5
`define STS_IRQ_W         6

// reset values
`define STS_CTRL_RST      2'h0
`define STS_TRAVEL_RST    16'h003c
`define STS_LIMIT_RST     16'h0fa0

// process figures, temperatures in 0.1 degree, output in 0.1 percent
`define STS_MIN_STEP      16'h0032
`define STS_OUT_FULL      16'h03e8
`define STS_OUT_ZERO      16'h0000
`define STS_PCT_START     7'h0c
`define STS_PCT_RISE1     7'h01
`define STS_PCT_RISE4     7'h04
`define STS_HALF_S_MS     32'h000001f4

// timing
`define STS_CLK_NS        10
`define STS_TICK_NS       1000000
`define STS_TICK_CYC      (`STS_TICK_NS / `STS_CLK_NS)
`define STS_MON_MS        60000
`define STS_FAIL_MS       1800000
`define STS_TRANS_MS      1000

// status word nibble codes
`define STS_ACT_MANUAL    4'h0
`define STS_ACT_CLOSED    4'h2
`define STS_ACT_OPTIM     4'h4
`define STS_ACT_TRANS     4'h6
`define STS_ERR_NONE      4'h0
`define STS_ERR_JUMP      4'h4
`define STS_ERR_RATIO     4'h5
`define STS_ERR_UNSETTLED 4'h6

`endif

// ### sts_pkg.sv
// types for the temperature self-tuning sequencer
package sts_pkg;

    typedef enum logic [1:0] {
        STS_IDLE    = 2'b00,
        STS_MONITOR = 2'b01,
        STS_HEAT    = 2'b10,
        STS_ERROR   = 2'b11
    } sts_state_t;

    typedef struct packed {
        logic [3:0] unused;
        logic [3:0] action;
        logic [3:0] ident;
        logic [3:0] err;
    } sts_word_t;

endpackage

// ### sts_timer.sv
// millisecond tick and elapsed-time counter
`timescale 1ns/1ns
`default_nettype none
module sts_timer #(
    parameter int TICK_CYC = 100000
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // control
    input  wire logic        clear_in,
    // outputs
    output logic             tick_out,
    output logic [31:0]      ms_out
);
    logic [31:0] div_r;
    logic [31:0] ms_r;
    wire         wrap = (div_r == 32'(TICK_CYC - 1));

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            div_r <= 32'h0;
        end else begin
            div_r <= wrap ? 32'h0 : div_r + 32'h1;
        end
    end

    // saturate so a stuck run never wraps into a false short time
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            ms_r <= 32'h0;
        end else if (wrap && ms_r != 32'hffffffff) begin
            ms_r <= ms_r + 32'h1;
        end
    end

    assign tick_out = wrap;
    assign ms_out   = ms_r;
endmodule
`default_nettype wire

// ### sts_seq_props.sv
// port checker for the self-tuning sequencer
`timescale 1ns/1ns
`default_nettype none
module sts_seq_props #(
    parameter int TICK_CYC = 100000,
    parameter int MON_MS   = 60000,
    parameter int FAIL_MS  = 1800000
)(
    // clock and reset
    input wire logic        REF_CLK_IN,
    input wire logic        RST_N_IN,
    // process inputs
    input wire logic        AUTO_MODE_IN,
    input wire logic        JUMP_ERR_IN,
    // results
    input wire logic [15:0] MANIP_OUT,
    input wire logic        RUNNING_OUT,
    input wire logic [15:0] STATUS_WORD_OUT
);
    logic [63:0] mon_r;
    logic [63:0] heat_r;
    wire         full_w = MANIP_OUT == 16'h03e8;
    wire  [3:0]  act_w  = STATUS_WORD_OUT[11:8];
    wire  [3:0]  err_w  = STATUS_WORD_OUT[3:0];

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // run lengths at zero and at full output; a restart in monitoring extends mon_r, one at full output clears heat_r
    always_ff @(posedge REF_CLK_IN) begin
        mon_r  <= (RST_N_IN && RUNNING_OUT && !full_w) ? mon_r + 64'h1 : 64'h0;
        heat_r <= (RST_N_IN && RUNNING_OUT && full_w) ? heat_r + 64'h1 : 64'h0;
    end

    property p_unused;
        STATUS_WORD_OUT[15:12] == 4'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("top nibble not zero");

    property p_trans;
        $rose(AUTO_MODE_IN) |-> ##[1:2] act_w == 4'h6;
    endproperty
    a_trans: assert property (p_trans) else $error("no transition code");

    property p_ident;
        STATUS_WORD_OUT[4] == RUNNING_OUT;
    endproperty
    a_ident: assert property (p_ident) else $error("running bit wrong");

    property p_errcode;
        err_w == 4'h0 || err_w == 4'h4 || err_w == 4'h5 || err_w == 4'h6;
    endproperty
    a_errcode: assert property (p_errcode) else $error("bad error code");

    property p_errzero;
        err_w != 4'h0 |-> MANIP_OUT == 16'h0 && !RUNNING_OUT;
    endproperty
    a_errzero: assert property (p_errzero) else $error("error state drives");

    property p_jump;
        RUNNING_OUT && JUMP_ERR_IN |=> !RUNNING_OUT && err_w == 4'h4;
    endproperty
    a_jump: assert property (p_jump) else $error("jump not cancelled");

    property p_runout;
        RUNNING_OUT |-> MANIP_OUT == 16'h0 || full_w;
    endproperty
    a_runout: assert property (p_runout) else $error("run output not 0 or full");

    property p_monitor;
        $rose(full_w) && RUNNING_OUT |-> mon_r >= 64'(MON_MS - 1) * 64'(TICK_CYC);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor too short");

    property p_fail;
        heat_r <= 64'(FAIL_MS + 2) * 64'(TICK_CYC);
    endproperty
    a_fail: assert property (p_fail) else $error("heat never given up");
endmodule

bind sts_seq sts_seq_props #(.TICK_CYC(TICK_CYC), .MON_MS(MON_MS), .FAIL_MS(FAIL_MS)) u_sts_seq_props (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .AUTO_MODE_IN(AUTO_MODE_IN), .JUMP_ERR_IN(JUMP_ERR_IN),
    .MANIP_OUT(MANIP_OUT), .RUNNING_OUT(RUNNING_OUT), .STATUS_WORD_OUT(STATUS_WORD_OUT)
);
`default_nettype wire

// ### sts_seq_test.sv
// self-checking bench for the self-tuning sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sts_cfg.svh"
module sts_seq_test;
    logic        clk, rst_n, wr_en, rd_en, auto_mode, jmp, rat, uns;
    logic [7:0]  addr;
    logic [31:0] wdata, d;
    logic [15:0] sp, act, ctl;
    wire  [31:0] rdata;
    wire  [15:0] manip, sw;
    wire         run, irq;
    int          n_errors, tests_run, n;

    // short counts: 1 ms is 10 cycles
    sts_seq #(.TICK_CYC(10), .MON_MS(5), .FAIL_MS(50), .TRANS_MS(3)) u_sts_seq (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata), .SETPOINT_IN(sp),
        .ACTUAL_IN(act), .AUTO_MODE_IN(auto_mode), .CTRL_OUT_IN(ctl),
        .JUMP_ERR_IN(jmp), .RATIO_ERR_IN(rat), .UNSETTLED_IN(uns),
        .MANIP_OUT(manip), .RUNNING_OUT(run), .STATUS_WORD_OUT(sw), .IRQ_OUT(irq));

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic set_sp(input logic [15:0] v);
        @(posedge clk);
        sp <= v;
        #1;
    endtask

    // bounded wait for a given output value; n counts the cycles
    task automatic wait_out(input logic [15:0] v, input int lim);
        n = 0;
        while (manip !== v) begin
            if (n == lim) begin
                n_errors++;
                $display("unexpected at %0t: waited %h, got %h", $time, v, manip);
                summarize();
            end
            tick(1);
            n++;
        end
    endtask

    task automatic t_regs;
        bus_rd(`STS_OFS_TRAVEL);
        chk(d, 32'h3c);
        tick(1);
        chk(rdata, 32'h0);
        bus_rd(`STS_OFS_LIMIT);
        chk(d, 32'hfa0);
        bus_rd(8'h20);
        chk(d, 32'h0);
        bus_wr(`STS_OFS_STATUS, 32'hffff);
        bus_rd(`STS_OFS_STATUS);
        chk(d, 32'h0);
        bus_wr(`STS_OFS_IRQ_MASK, 32'h3f);
        @(posedge clk);
        auto_mode <= 1'b1;
        tick(2);
        chk(sw, 16'h0600);
        tick(40);
        chk(sw, 16'h0200);
        $display("test regs done");
    endtask

    task automatic t_run;
        set_sp(16'd681);
        tick(2);
        chk(run, 1'b0);
        set_sp(16'd200);
        bus_wr(`STS_OFS_CTRL, 32'h1);
        chk(sw, 16'h0400);
        set_sp(16'd680);
        tick(2);
        chk(run, 1'b0);
        set_sp(16'd200);
        set_sp(16'd681);
        tick(1);
        chk(sw, 16'h0410);
        chk(irq, 1'b1);
        bus_wr(`STS_OFS_IRQ_MASK, 32'h3e);
        chk(irq, 1'b0);
        bus_wr(`STS_OFS_IRQ_MASK, 32'h3f);
        chk(irq, 1'b1);
        bus_wr(`STS_OFS_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        bus_wr(`STS_OFS_CTRL, 32'h0);
        wait_out(16'h03e8, 80);
        chk(32'(n >= 35 && n <= 55), 32'h1);
        chk(sw, 16'h0210);
        tick(19);
        @(posedge clk);
        act <= 16'd240;
        tick(19);
        @(posedge clk);
        act <= 16'd360;
        #1;
        wait_out(ctl, 5);
        chk(sw, 16'h0220);
        bus_rd(`STS_OFS_T1);
        chk(32'(d >= 1 && d <= 3), 32'h1);
        bus_rd(`STS_OFS_T4);
        chk(32'(d >= 3 && d <= 5), 32'h1);
        bus_rd(`STS_OFS_IRQ_STAT);
        chk(d, 32'h6);
        bus_wr(`STS_OFS_CTRL, 32'h4);
        chk(sw, 16'h0200);
        bus_wr(`STS_OFS_IRQ_STAT, 32'h3f);
        chk(irq, 1'b0);
        $display("test run done");
    endtask

    task automatic t_step;
        @(posedge clk);
        act <= 16'd200;
        set_sp(16'd200);
        bus_wr(`STS_OFS_TRAVEL, 32'h2);
        bus_wr(`STS_OFS_CTRL, 32'h3);
        set_sp(16'd1000);
        tick(100);
        chk(manip, 16'h0);
        set_sp(16'd300);
        tick(1);
        chk(run, 1'b0);
        bus_rd(`STS_OFS_IRQ_STAT);
        chk(d, 32'h9);
        bus_wr(`STS_OFS_IRQ_STAT, 32'h3f);
        set_sp(16'd1000);
        tick(30);
        chk(run, 1'b1);
        set_sp(16'd1500);
        wait_out(16'h03e8, 10200);
        chk(32'(n >= 10000 && n <= 10080), 32'h1);
        wait_out(16'h0, 530);
        chk(32'(n >= 485 && n <= 515), 32'h1);
        chk(sw, 16'h0400);
        bus_rd(`STS_OFS_IRQ_STAT);
        chk(d, 32'h23);
        $display("test step done");
    endtask

    // one pass per error code; several findings at once test the ranking
    task automatic t_crit;
        bus_wr(`STS_OFS_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            set_sp(16'd300);
            set_sp(16'd1000);
            tick(1);
            chk(sw[4:0], 5'h10);
            @(posedge clk);
            {uns, rat, jmp} <= 3'(3'b111 << i);
            @(posedge clk);
            {uns, rat, jmp} <= 3'b000;
            #1;
            chk(sw[3:0], 4'(4 + i));
            bus_wr(`STS_OFS_CTRL, 32'h0);
            tick(20);
            chk(manip, 16'h0);
            chk(sw[3:0], 4'(4 + i));
            bus_wr(`STS_OFS_CTRL, 32'h1);
        end
        $display("test crit done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        n_errors  = 0;
        tests_run = 0;
        rst_n     = 1'b0;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        addr      = 8'h0;
        wdata     = 32'h0;
        sp        = 16'd200;
        act       = 16'd200;
        auto_mode = 1'b0;
        ctl       = 16'h0123;
        {uns, rat, jmp} = 3'b000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_run();
        t_step();
        t_crit();
        summarize();
    end
endmodule
`default_nettype wire
